/* dlim_pkg.sv */
// constants for the dual level interrupt mask unit
package dlim_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register byte addresses
    localparam logic [31:0] ADDR_NORM_STATUS = 32'hffff0000;
    localparam logic [31:0] ADDR_NORM_RAW = 32'hffff0004;
    localparam logic [31:0] ADDR_NORM_EN = 32'hffff0008;
    localparam logic [31:0] ADDR_NORM_CLR = 32'hffff000c;
    localparam logic [31:0] ADDR_PROG_CTRL = 32'hffff0010;
    localparam logic [31:0] ADDR_VEC_BASE = 32'hffff0014;
    localparam logic [31:0] ADDR_VEC_PTR = 32'hffff001c;
    localparam logic [31:0] ADDR_PRI0 = 32'hffff0020;
    localparam logic [31:0] ADDR_VEC_CTRL = 32'hffff0030;
    localparam logic [31:0] ADDR_FAST_STATUS = 32'hffff0100;
    localparam logic [31:0] ADDR_FAST_RAW = 32'hffff0104;
    localparam logic [31:0] ADDR_FAST_EN = 32'hffff0108;
    localparam logic [31:0] ADDR_FAST_CLR = 32'hffff010c;

    ////////////////////////////////////////////////////////////////////////
    // field positions and sizes
    localparam int NUM_SRC = 32;
    localparam int FAST_OR_BIT = 0;
    localparam int SOFT_SRC_BIT = 1;
    localparam int FIRST_PERIPH_BIT = 2;
    localparam int PROG_NORM_BIT = 1;
    localparam int PROG_FAST_BIT = 2;
    localparam int VCTL_NORM_BIT = 0;
    localparam int VCTL_FAST_BIT = 1;
    localparam int BASE_W = 16;
    localparam int PRI_W = 3;
    localparam int NUM_LEVELS = 8;
    localparam int NUM_PRI_REGS = 4;
    localparam int PRI_FIELDS = 8;
    localparam int VEC_SRC_LSB = 2;
    localparam int VEC_BASE_LSB = 7;

    ////////////////////////////////////////////////////////////////////////
    // reset values and bus answers
    localparam logic [31:0] RST_WORD = 32'h00000000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* dlim_props.sv */
// bus and register-read checks for the interrupt mask unit
`timescale 1ns/1ps
module dlim_props (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // interrupt side
    input wire logic [31:0] src_irq,
    input wire logic normal_req,
    input wire logic fast_req,
    // write channels
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read channels
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire aw_t = s_axi_awvalid && s_axi_awready;
    wire w_t = s_axi_wvalid && s_axi_wready;
    wire ar_t = s_axi_arvalid && s_axi_arready;
    // everything of ours sits in the 0xffff0xxx page
    wire aw_bad = s_axi_awaddr[31:12] != 20'hffff0;
    wire ar_bad = s_axi_araddr[31:12] != 20'hffff0;
    wire ar_clr = s_axi_araddr == dlim_pkg::ADDR_NORM_CLR ||
        s_axi_araddr == dlim_pkg::ADDR_FAST_CLR;

    ////////////////////////////////////////////////////////////////////////
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    a_ar_answer: assert property (ar_t |=> !s_axi_arready && s_axi_rvalid)
        else $error("read not answered");
    a_aw_busy: assert property (aw_t |=> !s_axi_awready)
        else $error("awready stayed high");
    a_b_time: assert property (aw_t && w_t |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
    a_wr_slverr: assert property (aw_t && w_t && aw_bad |-> ##[1:2]
        (s_axi_bvalid && s_axi_bresp == dlim_pkg::RESP_SLVERR))
        else $error("unmapped write not refused");
    a_rd_slverr: assert property (ar_t && ar_bad |=>
        s_axi_rresp == dlim_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_clr_zero: assert property (ar_t && ar_clr |=> s_axi_rdata == 32'h0)
        else $error("clear register read nonzero");
    a_base_hi: assert property (ar_t && s_axi_araddr ==
        dlim_pkg::ADDR_VEC_BASE |=> s_axi_rdata[31:16] == 16'h0)
        else $error("base upper half nonzero");
    c_write: cover property (aw_t && w_t);
    c_read: cover property (ar_t && ar_clr);
    c_both: cover property (fast_req && normal_req);
endmodule

bind dlim_unit dlim_props chk_u (.*);

/* dlim_src_model.sv */
// far-side model: peripheral interrupt lines into the unit
`timescale 1ns/1ps
module dlim_src_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // level asked for by the bench
    input wire logic [31:0] new_src,
    input wire logic load,
    // lines into the unit
    output logic [31:0] src_irq
);
    logic [31:0] pend;
    logic [1:0] held;
    // a level is only replaced once it has stood four cycles
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            src_irq <= 32'h0;
            pend <= 32'h0;
            held <= 2'h0;
        end
        else
        begin
            if (load)
                pend <= new_src;
            if (held != 2'h3)
                held <= held + 2'h1;
            else if (pend != src_irq)
            begin
                src_irq <= pend;
                held <= 2'h0;
            end
        end
    end
endmodule

/* dlim_unit.sv */
// dual level interrupt mask unit with axi4-lite register slave
`timescale 1ns/1ps

// Overview of operation
// - normal status bits 31..2 are raw AND enable; ORed request
// - non-vectored mode: no encoding, software reads status
// - raw bits 31..2 follow peripheral interrupt lines, read-only
// - normal enable: write one sets, zero ignored
// - normal clear: write one clears that enable
// - fast enable and clear behave the same
// - fast status bits 31..1 ORed, bit 0
// - fast enable set clears normal enable bit
// - normal enable set clears fast enable bit
// - source may be disabled on both paths
// - programmed interrupts unmaskable, hit status and raw
// - control bit 2 drives fast bit 1
// - control bit 1 drives normal bit 1
// - vectored control bit 0 enables normal vectoring; bit 1 is only stored
// - eight nesting levels on the normal path only, fast first
// - sources 31..1 each have priority 0 to 7
// - vector base 16 bits, upper bits read zero
// - vector reads base and highest active source
// - same bit mapping on both paths
module dlim_unit (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // peripheral interrupt lines, bits 1 and 0 unused
    input wire logic [31:0] src_irq,
    // requests to the core
    output logic normal_req,
    output logic fast_req,
    // axi4-lite write address
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////
    // state
    logic [31:0] src_q;
    logic [31:0] norm_en;
    logic [31:0] fast_en;
    logic [31:0] norm_status;
    logic [31:0] fast_status;
    logic [31:0] norm_raw;
    logic [31:0] fast_raw;
    logic [1:0] prog;
    logic [1:0] vctl;
    logic [15:0] vec_base;
    logic [2:0] pri [32];
    logic [7:0] in_service;
    logic [4:0] vec_src;
    logic [2:0] vec_pri;
    logic vec_valid;
    logic aw_full;
    logic w_full;
    logic [31:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;

    ////////////////////////////////////////////////////////////////////////
    // next values of status and raw bits
    wire prog_norm = prog[0];
    wire prog_fast = prog[1];
    wire [29:0] periph = src_q[31:2];
    wire [30:0] fast_hi = {periph & fast_en[31:2], prog_fast};
    wire fast_or = |fast_hi;
    wire [31:0] next_fast_status = {fast_hi, fast_or};
    wire [31:0] next_fast_raw = {periph, prog_fast, fast_or};
    wire [31:0] next_norm_raw = {periph, prog_norm, fast_or};
    // bit 1 bypasses the mask: programmed interrupts cannot be masked
    wire [31:0] next_norm_status =
        {periph & norm_en[31:2], prog_norm, fast_or};

    ////////////////////////////////////////////////////////////////////////
    // write channel handshake and decode
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire do_write = aw_full & w_full & ~s_axi_bvalid;
    wire next_aw_full = aw_full ? ~do_write : aw_take;
    wire next_w_full = w_full ? ~do_write : w_take;
    wire next_bvalid = do_write | (s_axi_bvalid & ~s_axi_bready);
    wire [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                         {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    wire [31:0] wd = w_data_q & wmask;
    wire sel_norm_en = do_write & (aw_addr_q == dlim_pkg::ADDR_NORM_EN);
    wire sel_norm_clr = do_write & (aw_addr_q == dlim_pkg::ADDR_NORM_CLR);
    wire sel_fast_en = do_write & (aw_addr_q == dlim_pkg::ADDR_FAST_EN);
    wire sel_fast_clr = do_write & (aw_addr_q == dlim_pkg::ADDR_FAST_CLR);
    wire sel_prog = do_write & (aw_addr_q == dlim_pkg::ADDR_PROG_CTRL);
    wire sel_vctl = do_write & (aw_addr_q == dlim_pkg::ADDR_VEC_CTRL);
    wire sel_base = do_write & (aw_addr_q == dlim_pkg::ADDR_VEC_BASE);
    wire sel_vec = do_write & (aw_addr_q == dlim_pkg::ADDR_VEC_PTR);
    wire wr_pri = (aw_addr_q[31:4] == dlim_pkg::ADDR_PRI0[31:4]);
    // read-only registers answer okay but change nothing
    wire wr_ro = (aw_addr_q == dlim_pkg::ADDR_NORM_STATUS) |
                 (aw_addr_q == dlim_pkg::ADDR_NORM_RAW) |
                 (aw_addr_q == dlim_pkg::ADDR_FAST_STATUS) |
                 (aw_addr_q == dlim_pkg::ADDR_FAST_RAW);
    wire wr_hit = sel_norm_en | sel_norm_clr | sel_fast_en | sel_fast_clr |
                  sel_prog | sel_vctl | sel_base | sel_vec |
                  (do_write & (wr_pri | wr_ro));
    wire [31:0] norm_set = sel_norm_en ? wd : dlim_pkg::RST_WORD;
    wire [31:0] norm_clr = sel_norm_clr ? wd : dlim_pkg::RST_WORD;
    wire [31:0] fast_set = sel_fast_en ? wd : dlim_pkg::RST_WORD;
    wire [31:0] fast_clr = sel_fast_clr ? wd : dlim_pkg::RST_WORD;
    // zeros written to an enable leave it alone; both may end up zero
    wire [31:0] next_norm_en =
        (norm_en & ~norm_clr & ~fast_set) | norm_set;
    wire [31:0] next_fast_en =
        (fast_en & ~fast_clr & ~norm_set) | fast_set;
    wire [1:0] next_prog = (sel_prog & w_strb_q[0]) ?
        w_data_q[dlim_pkg::PROG_FAST_BIT:dlim_pkg::PROG_NORM_BIT] : prog;
    wire [1:0] next_vctl = (sel_vctl & w_strb_q[0]) ?
        w_data_q[1:0] : vctl;
    wire [15:0] next_base = (vec_base & ~wmask[15:0]) |
        (sel_base ? wd[15:0] : vec_base & wmask[15:0]);

    // priority fields: four words of eight nibbles, source 0 not stored
    logic [2:0] next_pri [32];
    always_comb
    begin
        for (int s = 0; s < dlim_pkg::NUM_SRC; s++)
        begin
            next_pri[s] = pri[s];
            if (do_write && wr_pri && s != 0 &&
                aw_addr_q[3:2] == 2'(s / dlim_pkg::PRI_FIELDS) &&
                w_strb_q[(s % dlim_pkg::PRI_FIELDS) / 2])
            begin
                next_pri[s] = w_data_q[4 * (s % 8) +: 3];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // highest priority pending normal source, lower value wins, then
    // lower bit number; bit 0 is the fast summary and is never vectored
    logic cand_valid;
    logic [2:0] cand_pri;
    logic [4:0] cand_src;
    always_comb
    begin
        cand_valid = 1'b0;
        cand_pri = 3'h7;
        cand_src = 5'h00;
        for (int s = dlim_pkg::NUM_SRC - 1; s >= 1; s--)
        begin
            if (norm_status[s] && (!cand_valid || pri[s] <= cand_pri))
            begin
                cand_valid = 1'b1;
                cand_pri = pri[s];
                cand_src = 5'(s);
            end
        end
    end

    // a request may preempt only levels strictly below it
    wire [8:0] le_levels = (9'h002 << cand_pri) - 9'h001;
    wire nest_ok = cand_valid & ((in_service & le_levels[7:0]) == 8'h00);
    wire fast_any = |fast_status[31:1];
    // in vectored mode fast outranks normal, so normal waits while fast is up
    wire next_normal_req = vctl[dlim_pkg::VCTL_NORM_BIT] ?
        (nest_ok & ~fast_any) : |norm_status;
    wire next_fast_req = fast_any;

    ////////////////////////////////////////////////////////////////////////
    // read channel
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire next_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);
    wire rd_vec = ar_take & (s_axi_araddr == dlim_pkg::ADDR_VEC_PTR);
    // reading the vector acknowledges the source and opens its level;
    // a write to the vector ends the innermost level
    wire push = rd_vec & vctl[dlim_pkg::VCTL_NORM_BIT] & vec_valid;
    wire [7:0] popped = sel_vec ? (in_service & (in_service - 8'h01))
                                : in_service;
    wire [7:0] next_in_service = popped | (push ? (8'h01 << vec_pri) : 8'h00);
    wire [31:0] vec_word = {9'h000, vec_base, vec_src, 2'h0};

    logic [31:0] rd_word;
    logic rd_hit;
    always_comb
    begin
        rd_word = dlim_pkg::RST_WORD;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            dlim_pkg::ADDR_NORM_STATUS: rd_word = norm_status;
            dlim_pkg::ADDR_NORM_RAW: rd_word = norm_raw;
            dlim_pkg::ADDR_NORM_EN: rd_word = norm_en;
            dlim_pkg::ADDR_NORM_CLR: rd_word = dlim_pkg::RST_WORD;
            dlim_pkg::ADDR_PROG_CTRL: rd_word = {29'h0, prog, 1'b0};
            dlim_pkg::ADDR_VEC_BASE: rd_word = {16'h0000, vec_base};
            dlim_pkg::ADDR_VEC_PTR: rd_word = vec_word;
            dlim_pkg::ADDR_VEC_CTRL: rd_word = {30'h0, vctl};
            dlim_pkg::ADDR_FAST_STATUS: rd_word = fast_status;
            dlim_pkg::ADDR_FAST_RAW: rd_word = fast_raw;
            dlim_pkg::ADDR_FAST_EN: rd_word = fast_en;
            dlim_pkg::ADDR_FAST_CLR: rd_word = dlim_pkg::RST_WORD;
            default:
            begin
                if (s_axi_araddr[31:4] == dlim_pkg::ADDR_PRI0[31:4])
                begin
                    for (int n = 0; n < dlim_pkg::PRI_FIELDS; n++)
                    begin
                        if (s_axi_araddr[3:2] != 2'h0 || n != 0)
                        begin
                            rd_word[4 * n +: 3] =
                                pri[{s_axi_araddr[3:2], 3'(n)}];
                        end
                    end
                end
                else
                begin
                    rd_hit = 1'b0;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            src_q <= dlim_pkg::RST_WORD;
            norm_en <= dlim_pkg::RST_WORD;
            fast_en <= dlim_pkg::RST_WORD;
            norm_status <= dlim_pkg::RST_WORD;
            fast_status <= dlim_pkg::RST_WORD;
            norm_raw <= dlim_pkg::RST_WORD;
            fast_raw <= dlim_pkg::RST_WORD;
            prog <= 2'h0;
            vctl <= 2'h0;
            vec_base <= 16'h0000;
            in_service <= 8'h00;
            vec_src <= 5'h00;
            vec_pri <= 3'h0;
            vec_valid <= 1'b0;
            normal_req <= 1'b0;
            fast_req <= 1'b0;
        end
        else
        begin
            src_q <= src_irq;
            norm_en <= next_norm_en;
            fast_en <= next_fast_en;
            norm_status <= next_norm_status;
            fast_status <= next_fast_status;
            norm_raw <= next_norm_raw;
            fast_raw <= next_fast_raw;
            prog <= next_prog;
            vctl <= next_vctl;
            vec_base <= next_base;
            in_service <= next_in_service;
            vec_src <= cand_src;
            vec_pri <= cand_pri;
            vec_valid <= cand_valid;
            normal_req <= next_normal_req;
            fast_req <= next_fast_req;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int s = 0; s < dlim_pkg::NUM_SRC; s++)
            begin
                pri[s] <= 3'h0;
            end
        end
        else
        begin
            pri <= next_pri;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus slave registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr_q <= dlim_pkg::RST_WORD;
            w_data_q <= dlim_pkg::RST_WORD;
            w_strb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= dlim_pkg::RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= dlim_pkg::RST_WORD;
            s_axi_rresp <= dlim_pkg::RESP_OKAY;
        end
        else
        begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            if (aw_take)
            begin
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_take)
            begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            s_axi_awready <= ~next_aw_full & ~next_bvalid;
            s_axi_wready <= ~next_w_full & ~next_bvalid;
            s_axi_bvalid <= next_bvalid;
            if (do_write)
            begin
                s_axi_bresp <= wr_hit ? dlim_pkg::RESP_OKAY
                                      : dlim_pkg::RESP_SLVERR;
            end
            s_axi_arready <= ~next_rvalid;
            s_axi_rvalid <= next_rvalid;
            if (ar_take)
            begin
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? dlim_pkg::RESP_OKAY
                                      : dlim_pkg::RESP_SLVERR;
            end
        end
    end

endmodule

/* tb.sv */
// self-checking bench for the dual level interrupt mask unit
`timescale 1ns/1ps
module tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] src_irq, s_axi_rdata;
    logic normal_req, fast_req, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
    logic [31:0] s_axi_araddr = 32'h0, nsrc = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ld = 1'b0;
    // bench copy of enables, programmed bits and source levels
    logic [31:0] nen = 32'h0, fen = 32'h0, prog = 32'h0, sv = 32'h0, d;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [31:0] opa [5] = '{dlim_pkg::ADDR_NORM_EN, dlim_pkg::ADDR_NORM_CLR,
        dlim_pkg::ADDR_FAST_EN, dlim_pkg::ADDR_FAST_CLR,
        dlim_pkg::ADDR_PROG_CTRL};
    logic [31:0] ra [6] = '{dlim_pkg::ADDR_NORM_RAW, dlim_pkg::ADDR_PROG_CTRL,
        dlim_pkg::ADDR_VEC_BASE, dlim_pkg::ADDR_VEC_CTRL,
        dlim_pkg::ADDR_FAST_RAW, dlim_pkg::ADDR_VEC_PTR};

    always #12.5 aclk = ~aclk;
    dlim_unit dut_u (.*);
    dlim_src_model src_u (.aclk(aclk), .aresetn(aresetn), .new_src(nsrc),
        .load(ld), .src_irq(src_irq));

    ////////////////////////////////////////////////////////////////////////
    function logic fo();
        return |{sv[31:2] & fen[31:2], prog[2]};
    endfunction
    function logic [31:0] e_nst();
        return {sv[31:2] & nen[31:2], prog[1], fo()};
    endfunction
    function logic [31:0] e_fst();
        return {sv[31:2] & fen[31:2], prog[2], fo()};
    endfunction

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (e !== g)
        begin
            $display("Error %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask
    task chk_bit(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask
    task print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // address and data both offered; bready held until bvalid is seen
    task wr(input logic [31:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task rd_chk(input logic [31:0] a, input logic [31:0] e, input string nm);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        chk(nm, e, s_axi_rdata);
    endtask

    // let raw, status and requests settle, then compare them all
    task check_all();
        repeat (6) @(posedge aclk);
        chk_bit("normal_req", |e_nst(), normal_req);
        chk_bit("fast_req", fo(), fast_req);
        rd_chk(dlim_pkg::ADDR_NORM_STATUS, e_nst(), "nstat");
        rd_chk(dlim_pkg::ADDR_FAST_STATUS, e_fst(), "fstat");
        rd_chk(dlim_pkg::ADDR_NORM_RAW, {sv[31:2], prog[1], fo()}, "nraw");
        rd_chk(dlim_pkg::ADDR_FAST_RAW, {sv[31:2], prog[2], fo()}, "fraw");
        rd_chk(dlim_pkg::ADDR_NORM_EN, nen, "nen");
        rd_chk(dlim_pkg::ADDR_FAST_EN, fen, "fen");
    endtask
    task op(input logic [31:0] a, input logic [31:0] v);
        wr(a, v);
        chk("bresp", {30'h0, dlim_pkg::RESP_OKAY}, {30'h0, rs});
        case (a)
            dlim_pkg::ADDR_NORM_EN: begin nen |= v; fen &= ~v; end
            dlim_pkg::ADDR_NORM_CLR: nen &= ~v;
            dlim_pkg::ADDR_FAST_EN: begin fen |= v; nen &= ~v; end
            dlim_pkg::ADDR_FAST_CLR: fen &= ~v;
            dlim_pkg::ADDR_PROG_CTRL: prog = v & 32'h6;
            default: ;
        endcase
        check_all();
    endtask
    task set_src(input logic [31:0] v);
        @(posedge aclk);
        nsrc <= v;
        ld <= 1'b1;
        @(posedge aclk);
        ld <= 1'b0;
        sv = v;
        check_all();
    endtask

    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            n_fail++;
            print_verdict();
        end
    end

    initial
    begin
        void'($urandom(32'h93aa));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        check_all();
        foreach (ra[i]) rd_chk(ra[i], 32'h0, "reset");
        // outside the register page, so the checker's refusal checks fire
        rd_chk(32'hfffe0200, 32'h0, "unmapped");
        chk("rresp", {30'h0, dlim_pkg::RESP_SLVERR}, {30'h0, rs});
        wr(32'hfffe0200, 32'hffffffff);
        chk("bresp", {30'h0, dlim_pkg::RESP_SLVERR}, {30'h0, rs});
        $display("done: reset and decode");
        wr(dlim_pkg::ADDR_VEC_BASE, 32'hffffffff);
        rd_chk(dlim_pkg::ADDR_VEC_BASE, 32'h0000ffff, "base");
        wr(dlim_pkg::ADDR_VEC_CTRL, 32'h3);
        rd_chk(dlim_pkg::ADDR_VEC_CTRL, 32'h3, "vctl");
        wr(dlim_pkg::ADDR_VEC_CTRL, 32'h0);
        $display("done: vector registers");
        set_src(32'hfffffff0);
        op(dlim_pkg::ADDR_NORM_EN, 32'hfffffffc);
        rd_chk(dlim_pkg::ADDR_NORM_CLR, 32'h0, "nclr");
        op(dlim_pkg::ADDR_NORM_EN, 32'h0);
        op(dlim_pkg::ADDR_FAST_EN, 32'h000000f0);
        rd_chk(dlim_pkg::ADDR_FAST_CLR, 32'h0, "fclr");
        op(dlim_pkg::ADDR_NORM_STATUS, 32'hffffffff);
        op(dlim_pkg::ADDR_FAST_RAW, 32'hffffffff);
        op(dlim_pkg::ADDR_NORM_CLR, 32'h0000000c);
        op(dlim_pkg::ADDR_FAST_CLR, 32'hfffffffe);
        // sources quiet before the wide clear, as software is told to do
        set_src(32'h0);
        op(dlim_pkg::ADDR_NORM_CLR, 32'hfffffffe);
        op(dlim_pkg::ADDR_PROG_CTRL, 32'h6);
        op(dlim_pkg::ADDR_PROG_CTRL, 32'h0);
        $display("done: corner writes");
        // source 6 at level 1 outranks source 4 at level 2
        wr(dlim_pkg::ADDR_PRI0, 32'h01020000);
        rd_chk(dlim_pkg::ADDR_PRI0, 32'h01020000, "pri");
        op(dlim_pkg::ADDR_NORM_EN, 32'h00000050);
        set_src(32'h00000050);
        wr(dlim_pkg::ADDR_VEC_CTRL, 32'h1);
        repeat (4) @(posedge aclk);
        chk_bit("vreq", 1'b1, normal_req);
        rd_chk(dlim_pkg::ADDR_VEC_PTR, {9'h000, 16'hffff, 5'h06, 2'h0},
            "vec");
        repeat (4) @(posedge aclk);
        chk_bit("nested", 1'b0, normal_req);
        wr(dlim_pkg::ADDR_VEC_PTR, 32'h0);
        repeat (4) @(posedge aclk);
        chk_bit("unnest", 1'b1, normal_req);
        wr(dlim_pkg::ADDR_VEC_CTRL, 32'h0);
        $display("done: vectored nesting");
        repeat (40)
        begin
            d = $urandom & 32'hfffffffe;
            if ($urandom_range(0, 5) == 5)
                set_src($urandom);
            else
                op(opa[$urandom_range(0, 4)], d);
        end
        $display("done: random traffic");
        print_verdict();
    end
endmodule
